// [inc/zcs_regs.vh]
`ifndef ZCS_REGS_VH
`define ZCS_REGS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ZCS_OFS_LEVEL 8'h00
`define ZCS_OFS_PERIOD 8'h04
`define ZCS_OFS_SELECT 8'h08
`define ZCS_OFS_OLTIMER 8'h0c
`define ZCS_OFS_ROUTE 8'h10
`define ZCS_OFS_STATUS 8'h14
`define ZCS_OFS_INTSTAT 8'h18
`define ZCS_OFS_INTMASK 8'h1c
// ----------------------------------------
// Reset values and ranges
// ----------------------------------------
// Level in 0.1 % of rated current
`define ZCS_LEVEL_RST 12'h032
`define ZCS_LEVEL_MAX 12'h7d0
// Period in 10 ms units
`define ZCS_PERIOD_RST 7'h32
`define ZCS_PERIOD_MAX 7'h64
`define ZCS_PERIOD_SHORT 7'h04
// Selection code
`define ZCS_SEL_RST 7'h01
`define ZCS_SEL_MAX 7'h1f
`define ZCS_SEL_DRIVE 7'h64
`define ZCS_SEL_REGEN 7'h65
// Overload timer in 0.1 s units
`define ZCS_OLT_RST 14'h0000
`define ZCS_OLT_MAX 14'h00fa
`define ZCS_OLT_OFF 14'h270f
`define ZCS_ROUTE_RST 4'h4
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ZCS_SEL_NOFAST 0
`define ZCS_SEL_NOACC 1
`define ZCS_SEL_NOCONST 2
`define ZCS_SEL_NODEC 3
`define ZCS_SEL_STOP 4
`define ZCS_EV_ZC 0
`define ZCS_EV_OL 1
`define ZCS_EV_STOP 2
`define ZCS_EV_SHUT 3
// ----------------------------------------
// Timing
// ----------------------------------------
`define ZCS_CLK_MHZ 25
`define ZCS_TICK_US 1000
`define ZCS_MIN_QUAL_MS 50
`define ZCS_HOLD_MS 100
`define ZCS_PERIOD_UNIT_MS 10
`define ZCS_OLT_UNIT_MS 100
`endif

// [src/zcs_timer.v]
`timescale 1ns/1ps
// ----------------------------------------
// Tick counter with threshold
// ----------------------------------------
module zcs_timer #(
	parameter W = 16
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Control
	input wire run,
	input wire tick,
	input wire [W-1:0] limit,
	// Result
	output reg done
);
	reg [W-1:0] count;

	// Saturates so a long wait cannot wrap back to zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= {W{1'b0}};
			done <= 1'b0;
		end else if (!run) begin
			count <= {W{1'b0}};
			done <= 1'b0;
		end else begin
			if (tick && count != {W{1'b1}})
				count <= count + 1'b1;
			done <= (count >= limit);
		end
	end
endmodule // zcs_timer

// [src/zcs_top.v]
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`include "zcs_regs.vh"
// Notes on behaviour
// - While running, flag after current stays below level longer than period.
// - Level is 0.1 % of rated current, 0 to 200 %, default 5 %.
// - Period counts from current dropping below level; up to 1 s, default 0.5 s.
// - After the condition ends, flag is held about 100 ms before release.
// - Period settings 0 to 0.04 s qualify in about 50 ms.
// - Detection stays active during online auto tuning.
// - Flag goes to the assigned open-collector terminal, displacing other functions.
// - Stall prevention under V/F lowers frequency when current exceeds limit.
// - Fast current limit shuts off output when current exceeds limit.
// - Overload alarm immediately, after delay up to 25 s, or never on 9999.
// - With stop-on-overload selected, stop drive and show stall stop alarm.
// - Codes 100 and 101 restrict stall prevention and fast limit to driving or regeneration.
module zcs_top #(
	parameter CUR_W = 12,
	parameter N_OC = 4,
	parameter TICK_CYCLES = `ZCS_TICK_US * `ZCS_CLK_MHZ
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Drive state
	input wire [CUR_W-1:0] out_current,
	input wire drive_running,
	input wire autotune_active,
	input wire vf_mode,
	input wire regen_mode,
	input wire [1:0] speed_phase,
	input wire over_limit,
	// Outputs
	output reg zero_current_flag,
	output reg overload_alarm,
	output reg freq_lower,
	output reg output_shutoff,
	output reg drive_stop,
	output reg stall_stop_alarm,
	output reg [N_OC-1:0] oc_out,
	output reg irq
);
	localparam PH_ACC = 2'b00;
	localparam PH_CONST = 2'b01;
	localparam PH_DEC = 2'b10;
	// Tick counts sized to the timer width
	localparam [15:0] MIN_QUAL = `ZCS_MIN_QUAL_MS;
	localparam [15:0] HOLD_TICKS = `ZCS_HOLD_MS;
	localparam [15:0] PERIOD_UNIT = `ZCS_PERIOD_UNIT_MS;
	localparam [15:0] OLT_UNIT = `ZCS_OLT_UNIT_MS;

	reg [CUR_W-1:0] zero_current_level;
	reg [6:0] zero_current_period;
	reg [6:0] stall_prevention_select;
	reg [13:0] overload_output_timer;
	reg [1:0] route_zc;
	reg [1:0] route_ol;
	reg [3:0] int_stat;
	reg [3:0] int_mask;
	reg [15:0] presc;
	reg tick;
	reg below;
	reg hold_run;
	reg ol_run;
	reg [15:0] qual_limit;
	reg [15:0] olt_limit;
	reg fast_en;
	reg stall_en;
	reg stop_sel;
	reg [31:0] next_prdata;
	reg next_slverr;
	reg [3:0] events;
	reg [N_OC-1:0] next_oc;
	wire qual_done;
	wire hold_done;
	wire ol_done;
	wire wr_en;
	wire ol_action;
	integer i;

	assign wr_en = psel & penable & pready & pwrite;
	assign ol_action = freq_lower | output_shutoff;

	// ----------------------------------------
	// APB access
	// ----------------------------------------
	// One wait state keeps read data coming straight from a flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			prdata <= next_prdata;
			pslverr <= next_slverr;
		end
	end

	always @* begin
		next_prdata = 32'h00000000;
		next_slverr = 1'b0;
		case (paddr)
		`ZCS_OFS_LEVEL: next_prdata[CUR_W-1:0] = zero_current_level;
		`ZCS_OFS_PERIOD: next_prdata[6:0] = zero_current_period;
		`ZCS_OFS_SELECT: next_prdata[6:0] = stall_prevention_select;
		`ZCS_OFS_OLTIMER: next_prdata[13:0] = overload_output_timer;
		`ZCS_OFS_ROUTE: next_prdata[3:0] = {route_ol, route_zc};
		`ZCS_OFS_STATUS: next_prdata[5:0] = {stall_stop_alarm, drive_stop,
			output_shutoff, freq_lower, overload_alarm, zero_current_flag};
		`ZCS_OFS_INTSTAT: next_prdata[3:0] = int_stat;
		`ZCS_OFS_INTMASK: next_prdata[3:0] = int_mask;
		default: next_slverr = 1'b1;
		endcase
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Out-of-range writes are dropped and the old setting stays
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_current_level <= `ZCS_LEVEL_RST;
			zero_current_period <= `ZCS_PERIOD_RST;
			stall_prevention_select <= `ZCS_SEL_RST;
			overload_output_timer <= `ZCS_OLT_RST;
			{route_ol, route_zc} <= `ZCS_ROUTE_RST;
			int_mask <= 4'h0;
		end else if (wr_en) begin
			case (paddr)
			`ZCS_OFS_LEVEL: if (pwdata[31:CUR_W] == 0 && pwdata[CUR_W-1:0] <= `ZCS_LEVEL_MAX)
				zero_current_level <= pwdata[CUR_W-1:0];
			`ZCS_OFS_PERIOD: if (pwdata[31:7] == 0 && pwdata[6:0] <= `ZCS_PERIOD_MAX)
				zero_current_period <= pwdata[6:0];
			`ZCS_OFS_SELECT: if (pwdata[31:7] == 0 && (pwdata[6:0] <= `ZCS_SEL_MAX ||
				pwdata[6:0] == `ZCS_SEL_DRIVE || pwdata[6:0] == `ZCS_SEL_REGEN))
				stall_prevention_select <= pwdata[6:0];
			`ZCS_OFS_OLTIMER: if (pwdata[31:14] == 0 && (pwdata[13:0] <= `ZCS_OLT_MAX ||
				pwdata[13:0] == `ZCS_OLT_OFF))
				overload_output_timer <= pwdata[13:0];
			`ZCS_OFS_ROUTE: {route_ol, route_zc} <= pwdata[3:0];
			`ZCS_OFS_INTMASK: int_mask <= pwdata[3:0];
			default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Control tick
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc <= 16'h0000;
			tick <= 1'b0;
		end else if (presc == TICK_CYCLES[15:0] - 16'h0001) begin
			presc <= 16'h0000;
			tick <= 1'b1;
		end else begin
			presc <= presc + 16'h0001;
			tick <= 1'b0;
		end
	end

	// ----------------------------------------
	// Zero current detection
	// ----------------------------------------
	always @* begin
		below = drive_running & (out_current < zero_current_level) |
			drive_running & autotune_active & (out_current < zero_current_level);
		if (zero_current_period <= `ZCS_PERIOD_SHORT)
			qual_limit = MIN_QUAL;
		else
			qual_limit = zero_current_period * PERIOD_UNIT;
		hold_run = zero_current_flag & ~below;
	end

	zcs_timer #(.W(16)) u_qual (
		.pclk(pclk),
		.presetn(presetn),
		.run(below),
		.tick(tick),
		.limit(qual_limit),
		.done(qual_done)
	);

	zcs_timer #(.W(16)) u_hold (
		.pclk(pclk),
		.presetn(presetn),
		.run(hold_run),
		.tick(tick),
		.limit(HOLD_TICKS),
		.done(hold_done)
	);

	// ----------------------------------------
	// Stall prevention select
	// ----------------------------------------
	always @* begin
		fast_en = 1'b0;
		stall_en = 1'b0;
		stop_sel = 1'b0;
		case (stall_prevention_select)
		`ZCS_SEL_DRIVE: begin
			fast_en = ~regen_mode;
			stall_en = ~regen_mode;
		end
		`ZCS_SEL_REGEN: begin
			fast_en = regen_mode;
			stall_en = regen_mode;
		end
		default: begin
			fast_en = ~stall_prevention_select[`ZCS_SEL_NOFAST];
			stop_sel = stall_prevention_select[`ZCS_SEL_STOP];
			case (speed_phase)
			PH_ACC: stall_en = ~stall_prevention_select[`ZCS_SEL_NOACC];
			PH_CONST: stall_en = ~stall_prevention_select[`ZCS_SEL_NOCONST];
			PH_DEC: stall_en = ~stall_prevention_select[`ZCS_SEL_NODEC];
			default: stall_en = 1'b0;
			endcase
		end
		endcase
	end

	// ----------------------------------------
	// Overload alarm delay
	// ----------------------------------------
	always @* begin
		// Off code overflows here, but the timer never runs then
		olt_limit = overload_output_timer * OLT_UNIT;
		ol_run = ol_action & (overload_output_timer != `ZCS_OLT_OFF);
	end

	zcs_timer #(.W(16)) u_olt (
		.pclk(pclk),
		.presetn(presetn),
		.run(ol_run),
		.tick(tick),
		.limit(olt_limit),
		.done(ol_done)
	);

	// ----------------------------------------
	// Outputs and events
	// ----------------------------------------
	always @* begin
		events = 4'h0;
		events[`ZCS_EV_ZC] = qual_done & ~zero_current_flag;
		events[`ZCS_EV_OL] = ol_done & ~overload_alarm;
		events[`ZCS_EV_STOP] = stop_sel & ol_action & ~drive_stop;
		events[`ZCS_EV_SHUT] = drive_running & over_limit & fast_en & ~output_shutoff;
		next_oc = {N_OC{1'b0}};
		for (i = 0; i < N_OC; i = i + 1) begin
			if (route_zc == i[1:0])
				next_oc[i] = zero_current_flag;
			else if (route_ol == i[1:0])
				next_oc[i] = overload_alarm;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_current_flag <= 1'b0;
			overload_alarm <= 1'b0;
			freq_lower <= 1'b0;
			output_shutoff <= 1'b0;
			drive_stop <= 1'b0;
			stall_stop_alarm <= 1'b0;
			oc_out <= {N_OC{1'b0}};
			int_stat <= 4'h0;
			irq <= 1'b0;
		end else begin
			if (qual_done)
				zero_current_flag <= 1'b1;
			else if (hold_done)
				zero_current_flag <= 1'b0;
			overload_alarm <= ol_done;
			freq_lower <= drive_running & vf_mode & over_limit & stall_en;
			output_shutoff <= drive_running & over_limit & fast_en;
			if (stop_sel & ol_action) begin
				drive_stop <= 1'b1;
				stall_stop_alarm <= 1'b1;
			end else if (!drive_running) begin
				drive_stop <= 1'b0;
			end
			oc_out <= next_oc;
			// Set beats a same-cycle clear
			if (wr_en && paddr == `ZCS_OFS_INTSTAT)
				int_stat <= (int_stat & ~pwdata[3:0]) | events;
			else
				int_stat <= int_stat | events;
			irq <= |(int_stat & int_mask);
		end
	end
endmodule // zcs_top

// [tb/tb_zcs_top.sv]
`timescale 1ns/1ps
`include "zcs_regs.vh"
module tb_zcs_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [11:0] out_current = 12'h3e8;
	logic drive_running = 1'b0;
	logic autotune_active = 1'b0;
	logic vf_mode = 1'b0;
	logic regen_mode = 1'b0;
	logic [1:0] speed_phase = 2'h0;
	logic over_limit = 1'b0;
	logic [31:0] rd;
	logic err;
	wire [31:0] prdata;
	wire [3:0] oc_out;
	wire pready, pslverr, zero_current_flag, overload_alarm, freq_lower;
	wire output_shutoff, drive_stop, stall_stop_alarm, irq, brake_closed;
	// Pull-up: transistor on pulls the line low
	wire term_line = oc_out[0] ? 1'b0 : 1'b1;
	int errors = 0;
	int comparisons = 0;

	always #20 pclk = ~pclk;

	zcs_top #(.TICK_CYCLES(10)) zcs_top_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .out_current(out_current),
		.drive_running(drive_running), .autotune_active(autotune_active),
		.vf_mode(vf_mode), .regen_mode(regen_mode), .speed_phase(speed_phase),
		.over_limit(over_limit), .zero_current_flag(zero_current_flag),
		.overload_alarm(overload_alarm), .freq_lower(freq_lower),
		.output_shutoff(output_shutoff), .drive_stop(drive_stop),
		.stall_stop_alarm(stall_stop_alarm), .oc_out(oc_out), .irq(irq)
	);
	zcs_brake zcs_brake_i (.pclk(pclk), .presetn(presetn), .term_line(term_line),
		.brake_closed(brake_closed));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic t_regs;
		apb(1'b0, `ZCS_OFS_LEVEL, 32'h0);
		chk(rd, 32'h32);
		apb(1'b0, `ZCS_OFS_PERIOD, 32'h0);
		chk(rd, 32'h32);
		apb(1'b0, `ZCS_OFS_SELECT, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, `ZCS_OFS_LEVEL, 32'h7d1);
		apb(1'b0, `ZCS_OFS_LEVEL, 32'h0);
		chk(rd, 32'h32);
		apb(1'b1, `ZCS_OFS_LEVEL, 32'h7d0);
		apb(1'b0, `ZCS_OFS_LEVEL, 32'h0);
		chk(rd, 32'h7d0);
		apb(1'b1, `ZCS_OFS_LEVEL, 32'h32);
		apb(1'b0, 8'h20, 32'h0);
		chk(err, 32'h1);
		$display("t_regs done");
	endtask
	task automatic t_zc;
		logic [6:0] p[3] = '{7'h00, 7'h04, 7'h0a};
		int t;
		drive_running <= 1'b1;
		autotune_active <= 1'b1;
		foreach (p[i]) begin
			t = (p[i] < 7'h05) ? 500 : p[i] * 100;
			apb(1'b1, `ZCS_OFS_PERIOD, p[i]);
			out_current <= 12'h00a;
			wt(t - 60);
			chk(zero_current_flag, 32'h0);
			wt(120);
			chk(zero_current_flag, 32'h1);
			chk(brake_closed, 32'h1);
			out_current <= 12'h3e8;
			wt(900);
			chk(zero_current_flag, 32'h1);
			wt(200);
			chk(zero_current_flag, 32'h0);
			chk(brake_closed, 32'h0);
		end
		$display("t_zc done");
	endtask
	task automatic t_sel;
		logic [6:0] c[11] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h0f, 7'h64, 7'h64, 7'h65,
			7'h65, 7'h00};
		logic [1:0] ph[11] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3};
		logic rg[11] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		logic [10:0] f = 11'b01001000011;
		logic [10:0] s = 11'b11001011101;
		vf_mode <= 1'b1;
		foreach (c[i]) begin
			apb(1'b1, `ZCS_OFS_SELECT, c[i]);
			speed_phase <= ph[i];
			regen_mode <= rg[i];
			over_limit <= 1'b1;
			wt(8);
			chk(freq_lower, f[i]);
			chk(output_shutoff, s[i]);
			chk(overload_alarm, f[i] | s[i]);
			over_limit <= 1'b0;
			wt(4);
		end
		regen_mode <= 1'b0;
		chk(stall_stop_alarm, 32'h0);
		$display("t_sel done");
	endtask
	task automatic t_ol;
		apb(1'b1, `ZCS_OFS_SELECT, 32'h1);
		speed_phase <= 2'h0;
		apb(1'b1, `ZCS_OFS_OLTIMER, 32'h270f);
		over_limit <= 1'b1;
		wt(50);
		chk(overload_alarm, 32'h0);
		over_limit <= 1'b0;
		wt(4);
		apb(1'b1, `ZCS_OFS_OLTIMER, 32'h1);
		over_limit <= 1'b1;
		wt(950);
		chk(overload_alarm, 32'h0);
		wt(100);
		chk(overload_alarm, 32'h1);
		chk(oc_out, 32'h2);
		apb(1'b1, `ZCS_OFS_ROUTE, 32'hc);
		wt(1);
		chk(oc_out, 32'h8);
		apb(1'b1, `ZCS_OFS_ROUTE, 32'h0);
		wt(1);
		chk(oc_out, 32'h0);
		apb(1'b1, `ZCS_OFS_ROUTE, 32'h4);
		chk(irq, 32'h0);
		apb(1'b1, `ZCS_OFS_INTMASK, 32'h2);
		wt(2);
		chk(irq, 32'h1);
		apb(1'b1, `ZCS_OFS_INTSTAT, 32'h2);
		wt(2);
		chk(irq, 32'h0);
		over_limit <= 1'b0;
		apb(1'b1, `ZCS_OFS_OLTIMER, 32'h0);
		$display("t_ol done");
	endtask
	task automatic t_stop;
		apb(1'b1, `ZCS_OFS_SELECT, 32'h10);
		over_limit <= 1'b1;
		wt(8);
		chk(drive_stop, 32'h1);
		chk(stall_stop_alarm, 32'h1);
		over_limit <= 1'b0;
		drive_running <= 1'b0;
		wt(8);
		chk(drive_stop, 32'h0);
		chk(stall_stop_alarm, 32'h1);
		apb(1'b0, `ZCS_OFS_STATUS, 32'h0);
		chk(rd, 32'h20);
		$display("t_stop done");
	endtask
	task automatic end_sim;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_zc;
		t_sel;
		t_ol;
		t_stop;
		end_sim;
	end
	// Run needs about 7000 cycles
	initial begin
		#1000000;
		errors++;
		end_sim;
	end
endmodule // tb_zcs_top

// [tb/zcs_brake.sv]
`timescale 1ns/1ps
module zcs_brake (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Pulled-up terminal line
	input wire term_line,
	// Brake state
	output reg brake_closed
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			brake_closed <= 1'b0;
		else
			brake_closed <= !term_line;
	end
endmodule // zcs_brake

// [tb/zcs_properties.sv]
`timescale 1ns/1ps
module zcs_properties #(
	parameter N_OC = 4
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Drive state
	input wire over_limit,
	input wire vf_mode,
	input wire drive_running,
	// Outputs
	input wire zero_current_flag,
	input wire overload_alarm,
	input wire freq_lower,
	input wire output_shutoff,
	input wire drive_stop,
	input wire stall_stop_alarm,
	input wire [N_OC-1:0] oc_out
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_zc_run: assert property ($rose(zero_current_flag) |-> $past(drive_running, 2))
		else $error("zc flag without run");
	a_zc_hold: assert property ($rose(zero_current_flag) |=> zero_current_flag [*8])
		else $error("zc flag too short");
	a_zc_term: assert property ($rose(zero_current_flag) |=> |oc_out)
		else $error("zc flag not on terminal");
	a_lower_cause: assert property ($rose(freq_lower) |-> $past(vf_mode && over_limit))
		else $error("freq lower without cause");
	a_shut_cause: assert property ($rose(output_shutoff) |-> $past(over_limit))
		else $error("shutoff without cause");
	a_ol_cause: assert property ($rose(overload_alarm) |-> $past(freq_lower | output_shutoff, 2))
		else $error("overload without action");
	a_stop_cause: assert property ($rose(drive_stop) |-> $past(freq_lower | output_shutoff))
		else $error("stop without overload");
	a_stop_sticky: assert property ($rose(stall_stop_alarm) |=> stall_stop_alarm [*8])
		else $error("stop alarm dropped");
endmodule // zcs_properties

bind zcs_top zcs_properties #(.N_OC(N_OC)) zcs_properties_i (
	.pclk(pclk), .presetn(presetn), .over_limit(over_limit), .vf_mode(vf_mode),
	.drive_running(drive_running), .zero_current_flag(zero_current_flag),
	.overload_alarm(overload_alarm), .freq_lower(freq_lower),
	.output_shutoff(output_shutoff), .drive_stop(drive_stop),
	.stall_stop_alarm(stall_stop_alarm), .oc_out(oc_out)
);
